// >>> common/hba_consts.svh
`ifndef HBA_CONSTS_SVH
`define HBA_CONSTS_SVH

// APB map: bit 10 picks the configuration space, else the device window
`define HBA_CFG_SPACE_BIT 10
`define HBA_SECT_BIT 9
`define HBA_CHAN_BIT 8
`define HBA_AD_MSB 7
`define HBA_AD_LSB 2
`define HBA_BCR_OFFS 12'h400
`define HBA_STAT_OFFS 12'h404

// Bus configuration register fields and reset value
`define HBA_BCR_RST 5'h00
`define HBA_BCR_W 5
`define HBA_BCR_DMA_SHL 0
`define HBA_BCR_MUXED 1
`define HBA_BCR_WAIT 2
`define HBA_BCR_INTACK 3
`define HBA_BCR_LANE 4

// Command register fields
`define HBA_CMD_PTR_MSB 2
`define HBA_CMD_CODE_MSB 5
`define HBA_CMD_CODE_LSB 3
`define HBA_CMD_POINT_HIGH 3'h1
`define HBA_SHIFT_MSB 1
`define HBA_SER_SHL_CODE 2'h1

// Pointer widths and reset values
`define HBA_SPTR_W 4
`define HBA_DPTR_W 5
`define HBA_SPTR_RST 4'h0
`define HBA_DPTR_RST 5'h00
`define HBA_SER_REGS 32
`define HBA_DMA_REGS 32

`endif

// >>> common/hba_pkg.sv
package hba_pkg;

  // Host-programmable bus configuration
  typedef struct packed {
    logic lane_hi;
    logic intack_vec;
    logic wait_ext;
    logic muxed;
    logic dma_shl;
  } hba_cfg_t;

  // Target of a host access
  typedef enum logic [1:0] {
    HBA_TGT_CHB = 2'b00,
    HBA_TGT_CHA = 2'b01,
    HBA_TGT_DMA = 2'b10,
    HBA_TGT_CFG = 2'b11
  } hba_tgt_t;

  // Bus-master drive of the select pins
  typedef struct packed {
    logic sect;
    logic chan;
  } hba_sel_t;

endpackage

// >>> rtl/hba_ptr.sv
`timescale 1ns/10ps
`include "hba_consts.svh"

// Auto-clearing register pointer, one instance per section
module hba_ptr #(
  parameter int W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic clr,
  output logic [W-1:0] ptr
);

  logic [W-1:0] ptr_r;
  logic [W-1:0] ptr_nxt;

  // Clear wins: the second access always returns to the base register
  always_comb begin
    ptr_nxt = ptr_r;
    if (clr) begin
      ptr_nxt = '0;
    end else if (load) begin
      ptr_nxt = load_val;
    end
  end

  // Cleared on reset so the first access hits the base register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_r <= '0;
    end else begin
      ptr_r <= ptr_nxt;
    end
  end

  assign ptr = ptr_r;

endmodule

// >>> rtl/hba_host_port.sv
`timescale 1ns/10ps
`include "hba_consts.svh"

module hba_host_port
  import hba_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dma_master,
  input wire logic dma_section,
  input wire logic dma_channel,
  output logic section_select_o,
  output logic section_select_oe,
  output logic channel_select_o,
  output logic channel_select_oe,
  output logic bus_muxed,
  output logic intack_vectored
);

  // Decode used by both the answer path and the update path
  function automatic hba_tgt_t hba_decode(input logic [11:0] a);
    if (a[`HBA_CFG_SPACE_BIT]) begin
      hba_decode = HBA_TGT_CFG;
    end else if (!a[`HBA_SECT_BIT]) begin
      hba_decode = HBA_TGT_DMA;
    end else if (a[`HBA_CHAN_BIT]) begin
      hba_decode = HBA_TGT_CHA;
    end else begin
      hba_decode = HBA_TGT_CHB;
    end
  endfunction

  // Multiplexed register index from the address/data field
  function automatic logic [4:0] hba_mux_idx(input logic [5:0] ad,
                                             input logic shl);
    hba_mux_idx = shl ? ad[5:1] : ad[4:0];
  endfunction

  hba_cfg_t cfg_r;
  hba_cfg_t cfg_nxt;
  logic [1:0] ser_shift_r;
  logic [1:0] ser_shift_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic wait_cnt_r;
  logic wait_cnt_nxt;
  hba_sel_t sel_o_r;
  hba_sel_t sel_o_nxt;
  logic sel_oe_r;
  logic sel_oe_nxt;

  logic [7:0] ser_mem [0:`HBA_SER_REGS-1];
  logic [7:0] dma_mem [0:`HBA_DMA_REGS-1];

  logic [`HBA_SPTR_W-1:0] sptr;
  logic [`HBA_DPTR_W-1:0] dptr;
  logic s_load;
  logic s_clr;
  logic [`HBA_SPTR_W-1:0] s_load_val;
  logic d_load;
  logic d_clr;
  logic [`HBA_DPTR_W-1:0] d_load_val;
  logic ser_we;
  logic [4:0] ser_waddr;
  logic dma_we;
  logic [4:0] dma_waddr;

  hba_tgt_t tgt;
  logic [5:0] ad;
  logic ch_bit;
  logic [4:0] ser_midx;
  logic [4:0] dma_midx;
  logic access;
  logic done;
  logic cfg_err;
  logic [7:0] rd_byte;
  logic [7:0] ser_stat;

  // Separate pointers for the two sections
  hba_ptr #(.W(`HBA_SPTR_W)) u_ser_ptr (
    .pclk(pclk),
    .presetn(presetn),
    .load(s_load),
    .load_val(s_load_val),
    .clr(s_clr),
    .ptr(sptr)
  );

  hba_ptr #(.W(`HBA_DPTR_W)) u_dma_ptr (
    .pclk(pclk),
    .presetn(presetn),
    .load(d_load),
    .load_val(d_load_val),
    .clr(d_clr),
    .ptr(dptr)
  );

  // Address fields and phase decode; psel is the decoded chip select
  always_comb begin
    tgt = hba_decode(paddr);
    ad = paddr[`HBA_AD_MSB:`HBA_AD_LSB];
    ch_bit = (tgt == HBA_TGT_CHA);
    ser_midx = hba_mux_idx(ad, ser_shift_r == `HBA_SER_SHL_CODE);
    dma_midx = hba_mux_idx(ad, cfg_r.dma_shl);
    access = psel && penable && !pready_r;
    done = psel && penable && pready_r;
    cfg_err = (tgt == HBA_TGT_CFG) && (paddr != `HBA_BCR_OFFS)
              && (paddr != `HBA_STAT_OFFS);
    ser_stat = {3'h0, ch_bit, sptr};
  end

  // Read answer, taken from state before the completing edge
  always_comb begin
    rd_byte = 8'h00;
    unique case (tgt)
      HBA_TGT_CFG: begin
        if (paddr == `HBA_BCR_OFFS) begin
          rd_byte = {3'h0, cfg_r};
        end else if (paddr == `HBA_STAT_OFFS) begin
          rd_byte = {cfg_r.muxed, 2'h0, dptr};
        end
      end
      HBA_TGT_DMA: begin
        if (cfg_r.muxed) begin
          rd_byte = dma_mem[dma_midx];
        end else if (dptr == `HBA_DPTR_RST) begin
          rd_byte = {3'h0, dptr};
        end else begin
          rd_byte = dma_mem[dptr];
        end
      end
      default: begin
        if (cfg_r.muxed) begin
          if (ser_midx[3:0] == `HBA_SPTR_RST) begin
            rd_byte = ser_stat;
          end else begin
            rd_byte = ser_mem[{ch_bit, ser_midx[3:0]}];
          end
        end else if (sptr == `HBA_SPTR_RST) begin
          rd_byte = ser_stat;
        end else begin
          rd_byte = ser_mem[{ch_bit, sptr}];
        end
      end
    endcase
  end

  // APB handshake: one wait state, two with the extended wait style
  always_comb begin
    pready_nxt = 1'b0;
    wait_cnt_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt = prdata_r;
    if (access) begin
      if (wait_cnt_r == cfg_r.wait_ext) begin
        pready_nxt = 1'b1;
        pslverr_nxt = cfg_err;
        if (!pwrite) begin
          // Byte lane style: replicate on upper byte or keep it zero
          prdata_nxt = cfg_r.lane_hi ? {16'h0000, rd_byte, rd_byte}
                                     : {24'h000000, rd_byte};
        end
      end else begin
        wait_cnt_nxt = 1'b1;
      end
    end
  end

  // Configuration, command interpretation and pointer steering
  always_comb begin
    cfg_nxt = cfg_r;
    ser_shift_nxt = ser_shift_r;
    s_load = 1'b0;
    s_clr = 1'b0;
    s_load_val = `HBA_SPTR_RST;
    d_load = 1'b0;
    d_clr = 1'b0;
    d_load_val = pwdata[`HBA_DPTR_W-1:0];
    ser_we = 1'b0;
    ser_waddr = {ch_bit, sptr};
    dma_we = 1'b0;
    dma_waddr = dptr;
    if (done && !pslverr_r) begin
      unique case (tgt)
        HBA_TGT_CFG: begin
          if (pwrite && paddr == `HBA_BCR_OFFS) begin
            cfg_nxt = pwdata[`HBA_BCR_W-1:0];
          end
        end
        HBA_TGT_DMA: begin
          if (cfg_r.muxed) begin
            dma_we = pwrite;
            dma_waddr = dma_midx;
          end else if (dptr == `HBA_DPTR_RST) begin
            d_load = pwrite;
          end else begin
            dma_we = pwrite;
            d_clr = 1'b1;
          end
        end
        default: begin
          if (cfg_r.muxed) begin
            ser_we = pwrite;
            ser_waddr = {ch_bit, ser_midx[3:0]};
            if (pwrite && ser_midx[3:0] == `HBA_SPTR_RST) begin
              ser_shift_nxt = pwdata[`HBA_SHIFT_MSB:0];
            end
          end else if (sptr == `HBA_SPTR_RST) begin
            // Command form: pointer bits plus command code
            ser_we = pwrite;
            s_load = pwrite;
            s_load_val = {pwdata[`HBA_CMD_CODE_MSB:`HBA_CMD_CODE_LSB]
                          == `HBA_CMD_POINT_HIGH,
                          pwdata[`HBA_CMD_PTR_MSB:0]};
          end else begin
            ser_we = pwrite;
            s_clr = 1'b1;
          end
        end
      endcase
    end
  end

  // Select pins only driven while the device owns the bus
  always_comb begin
    sel_oe_nxt = dma_master;
    sel_o_nxt.sect = dma_master ? dma_section : 1'b0;
    sel_o_nxt.chan = dma_master ? dma_channel : 1'b0;
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= `HBA_BCR_RST;
      ser_shift_r <= 2'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
      wait_cnt_r <= 1'b0;
      sel_o_r <= 2'h0;
      sel_oe_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      ser_shift_r <= ser_shift_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
      wait_cnt_r <= wait_cnt_nxt;
      sel_o_r <= sel_o_nxt;
      sel_oe_r <= sel_oe_nxt;
    end
  end

  // Register storage; no reset, contents are set up by the host
  always_ff @(posedge pclk) begin
    if (ser_we) begin
      ser_mem[ser_waddr] <= pwdata[7:0];
    end
    if (dma_we) begin
      dma_mem[dma_waddr] <= pwdata[7:0];
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign section_select_o = sel_o_r.sect;
  assign channel_select_o = sel_o_r.chan;
  assign section_select_oe = sel_oe_r;
  assign channel_select_oe = sel_oe_r;
  assign bus_muxed = cfg_r.muxed;
  assign intack_vectored = cfg_r.intack_vec;

endmodule

// >>> testbench/hba_host_port_asserts.sv
`timescale 1ns/10ps
`include "hba_consts.svh"

// Pin-level checks of the host port
module hba_host_port_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic dma_master,
  input wire logic dma_section,
  input wire logic dma_channel,
  input wire logic section_select_o,
  input wire logic section_select_oe,
  input wire logic channel_select_o,
  input wire logic channel_select_oe,
  input wire logic bus_muxed,
  input wire logic intack_vectored
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Config write in its access phase
  wire cfg_wr = psel && penable && pwrite && paddr == `HBA_BCR_OFFS;
  wire cfg_bad = paddr != `HBA_BCR_OFFS && paddr != `HBA_STAT_OFFS;

  ready_one_shot_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_cause_a: assert property (pready |-> psel && $past(psel && penable))
    else $error("pready without access phase");
  quiet_unsel_a: assert property (!psel |-> !pready && !pslverr)
    else $error("answer without select");
  window_no_err_a: assert property (pready && !paddr[10] |-> !pslverr)
    else $error("error on window access");
  cfg_unmapped_a: assert property (pready && paddr[10] && cfg_bad |-> pslverr)
    else $error("unmapped config not refused");
  mode_load_a: assert property (cfg_wr && pready |=>
    bus_muxed == $past(pwdata[1]) && intack_vectored == $past(pwdata[3]))
    else $error("config bits not applied");
  mode_hold_a: assert property (!(cfg_wr && pready) |=> $stable(bus_muxed))
    else $error("bus mode moved");
  pin_enable_a: assert property (##1 section_select_oe == $past(dma_master)
    && channel_select_oe == $past(dma_master)) else $error("oe wrong");
  pin_drive_a: assert property (dma_master |=>
    section_select_o == $past(dma_section) && channel_select_o == $past(dma_channel))
    else $error("pin drive wrong");
  pin_idle_a: assert property (!dma_master |=> !section_select_o && !channel_select_o)
    else $error("pins driven as slave");
endmodule

bind hba_host_port hba_host_port_asserts u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .dma_master(dma_master), .dma_section(dma_section),
  .dma_channel(dma_channel), .section_select_o(section_select_o),
  .section_select_oe(section_select_oe), .channel_select_o(channel_select_o),
  .channel_select_oe(channel_select_oe), .bus_muxed(bus_muxed),
  .intack_vectored(intack_vectored));

// >>> testbench/hba_host_bfm.sv
`timescale 1ns/10ps

// Host processor side: an APB master
module hba_host_bfm (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end

  // One transfer; an edge always passes before the next setup
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic ok);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Look at pready once settled, away from the edge that launches it
    @(negedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(negedge pclk);
    end
    // The completing edge: the slave samples the request with pready high
    @(posedge pclk);
    // Released lines show junk, not the last value
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    ok = n < 20;
  endtask
endmodule

// >>> testbench/tb_host_bus_register_addressing.sv
`timescale 1ns/10ps

module tb_host_bus_register_addressing;
  import hba_pkg::*;
  typedef struct packed {logic rd; logic er; logic [31:0] d;} hba_note_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic dma_master = 1'b0;
  logic dma_section = 1'b0;
  logic dma_channel = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic sso, ssoe, cso, csoe, bus_muxed, intack_vectored;
  logic [7:0] b;
  logic s, c;
  int err_total = 0;
  int n_checks = 0;
  hba_note_t exp_q[$];
  hba_note_t note;

  always #20 pclk = ~pclk;

  hba_host_bfm u_host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  hba_host_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dma_master(dma_master), .dma_section(dma_section),
    .dma_channel(dma_channel), .section_select_o(sso),
    .section_select_oe(ssoe), .channel_select_o(cso),
    .channel_select_oe(csoe), .bus_muxed(bus_muxed),
    .intack_vectored(intack_vectored));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task end_of_test;
    $display("checks=%0d mismatches=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Note the answer, then run the transfer
  task automatic go(input logic w, input logic [11:0] a,
                    input logic [31:0] d, input logic [31:0] e, input logic er);
    logic ok;
    exp_q.push_back('{~w, er, e});
    u_host.xfer(w, a, d, ok);
    if (!ok) begin
      err_total++;
      end_of_test();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    go(1'b1, a, d, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    go(1'b0, a, 32'h0, e, 1'b0);
  endtask

  // Each answered transfer retires the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      note = exp_q.pop_front();
      chk({31'h0, pslverr}, {31'h0, note.er});
      if (note.rd) chk(prdata, note.d);
    end
  end

  initial begin
    void'($urandom(87));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h404, 32'h0);
    rd(12'h300, 32'h10);
    // Pointer then data on each channel; status proves the clear
    for (int i = 0; i < 2; i++) begin
      b = 8'($urandom);
      wr({3'h1, i[0], 8'h00}, 32'h5);
      wr({3'h1, i[0], 8'h00}, {24'h0, b});
      rd({3'h1, i[0], 8'h00}, {27'h0, i[0], 4'h0});
      wr({3'h1, i[0], 8'h00}, 32'h5);
      rd({3'h1, i[0], 8'h00}, {24'h0, b});
    end
    wr(12'h300, 32'h0d);
    wr(12'h300, 32'h3c);
    wr(12'h300, 32'h05);
    rd(12'h300, {24'h0, b});
    wr(12'h300, 32'h0d);
    rd(12'h300, 32'h3c);
    // DMA pointer lives apart from the serial one
    wr(12'h000, 32'h13);
    rd(12'h404, 32'h13);
    rd(12'h300, 32'h10);
    wr(12'h300, 32'h02);
    wr(12'h300, 32'h44);
    rd(12'h404, 32'h13);
    wr(12'h000, 32'h5a);
    rd(12'h404, 32'h0);
    wr(12'h000, 32'h13);
    rd(12'h000, 32'h5a);
    go(1'b1, 12'h408, 32'h0, 32'h0, 1'b1);
    // Multiplexed mode with both shift settings
    wr(12'h400, 32'h0a);
    @(negedge pclk);
    chk({30'h0, bus_muxed, intack_vectored}, 32'h3);
    rd(12'h404, 32'h80);
    wr(12'h318, 32'h77);
    rd(12'h318, 32'h77);
    wr(12'h300, 32'h1);
    rd(12'h330, 32'h77);
    rd(12'h04c, 32'h5a);
    wr(12'h400, 32'h1f);
    rd(12'h098, 32'h5a5a);
    // Select pins handed to the DMA side
    repeat (4) begin
      s = 1'($urandom);
      c = 1'($urandom);
      @(posedge pclk);
      dma_master <= 1'b1;
      dma_section <= s;
      dma_channel <= c;
      @(posedge pclk);
      @(negedge pclk);
      chk({28'h0, sso, cso, ssoe, csoe}, {28'h0, s, c, 2'b11});
    end
    @(posedge pclk);
    dma_master <= 1'b0;
    // Reset in mid-run
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h300, 32'h10);
    @(negedge pclk);
    chk({31'h0, bus_muxed}, 32'h0);
    end_of_test();
  end
endmodule
